// ==== include/stap_pkg.sv ====
// Contract
// - TMS is sampled into the TAP state machine on each rising TCK edge.
// - Rising TCK shifts TDI into the selected instruction or data register.
// - The selected register shifts out on TDO, one bit per TCK cycle.
// - TDO changes only on falling TCK edges.
// - TDO floats except while a register is being shifted.
// - TRST high gives the scan system control; the controller must drive it.
// - TRST low or open: functional mode, all scan inputs ignored.
// - TRST high: each emulation pin is an interrupt, direction set by scan.
`default_nettype none
package stap_pkg;
    typedef enum logic [3:0] {
        st_tlr    = 4'h0,
        st_rti    = 4'h1,
        st_sel_dr = 4'h2,
        st_cap_dr = 4'h3,
        st_sh_dr  = 4'h4,
        st_ex1_dr = 4'h5,
        st_pau_dr = 4'h6,
        st_ex2_dr = 4'h7,
        st_upd_dr = 4'h8,
        st_sel_ir = 4'h9,
        st_cap_ir = 4'ha,
        st_sh_ir  = 4'hb,
        st_ex1_ir = 4'hc,
        st_pau_ir = 4'hd,
        st_ex2_ir = 4'he,
        st_upd_ir = 4'hf
    } stap_state_e;

    localparam int          IR_W        = 4;
    localparam int          DR_W        = 32;
    localparam int          LEN_W       = 6;
    localparam int          EMU_W       = 2;
    localparam logic [3:0]  IR_IDCODE   = 4'h1;
    localparam logic [3:0]  IR_EMUCTL   = 4'h2;
    localparam logic [3:0]  IR_BYPASS   = 4'hf;
    localparam logic [3:0]  IR_CAPTURE  = 4'h1;
    localparam logic [3:0]  IR_RESET    = 4'h1;
    localparam logic [5:0]  LEN_IDCODE  = 6'h20;
    localparam logic [5:0]  LEN_EMUCTL  = 6'h02;
    localparam logic [5:0]  LEN_BYPASS  = 6'h01;
    localparam logic [1:0]  EMU_DIR_RST = 2'h0;
    // Identification value is arbitrary; bit 0 must stay set.
    localparam logic [31:0] IDCODE_DEF  = 32'h0a5c_0001;
    // Positions of the pin inputs inside the synchroniser vector.
    localparam int          SYNC_W      = 6;
    localparam int          B_TCK       = 0;
    localparam int          B_TMS       = 1;
    localparam int          B_TDI       = 2;
    localparam int          B_TRST      = 3;
    localparam int          B_EMU_A     = 4;
    localparam int          B_EMU_B     = 5;
endpackage
`default_nettype wire

// ==== logic/stap_core.sv ====
`default_nettype none
// Scan test access port, oversampling TCK with the system clock.
module stap_core #(
    parameter logic [31:0] IDCODE_VALUE = stap_pkg::IDCODE_DEF
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic tdi,
    input  wire logic trst,
    output logic      tdo,
    output logic      tdo_oe_n,
    input  wire logic emulator_irq_line_a_in,
    output logic      emulator_irq_line_a_out,
    output logic      emulator_irq_line_a_oe_n,
    input  wire logic emulator_irq_line_b_in,
    output logic      emulator_irq_line_b_out,
    output logic      emulator_irq_line_b_oe_n,
    input  wire logic core_irq_a,
    input  wire logic core_irq_b,
    output logic      emu_irq_a,
    output logic      emu_irq_b,
    output logic      scan_mode
);
    typedef struct packed {
        stap_pkg::stap_state_e state;
        logic [3:0]            ir;
        logic [3:0]            ir_sh;
        logic [31:0]           dr;
        logic [1:0]            emu_dir;
        logic                  tck_prev;
        logic                  tdo;
        logic                  tdo_oe_n;
        logic [1:0]            emu_out;
        logic [1:0]            emu_oe_n;
        logic [1:0]            emu_irq;
        logic                  scan;
    } stap_core_s;

    stap_core_s st;
    stap_core_s next_st;
    logic [stap_pkg::SYNC_W-1:0] pins;
    logic s_tck, s_tms, s_tdi, s_trst;
    logic [1:0] s_emu;
    logic [1:0] core_irq;
    logic rise, fall;
    logic [5:0] dr_len;

    // Every pin passes two flops; TMS and TDI share the TCK delay.
    stap_sync #(
        .W(stap_pkg::SYNC_W)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .din  ({emulator_irq_line_b_in, emulator_irq_line_a_in, trst,
                tdi, tms, tck}),
        .dout (pins)
    );

    assign s_tck    = pins[stap_pkg::B_TCK];
    assign s_tms    = pins[stap_pkg::B_TMS];
    assign s_tdi    = pins[stap_pkg::B_TDI];
    assign s_trst   = pins[stap_pkg::B_TRST];
    assign s_emu    = {pins[stap_pkg::B_EMU_B], pins[stap_pkg::B_EMU_A]};
    assign core_irq = {core_irq_b, core_irq_a};
    assign rise     = s_tck & ~st.tck_prev;
    assign fall     = ~s_tck & st.tck_prev;

    // Standard sixteen-state successor table.
    function automatic stap_pkg::stap_state_e next_tap(
        input stap_pkg::stap_state_e s,
        input logic                  m
    );
        stap_pkg::stap_state_e n;
        n = stap_pkg::st_tlr;
        unique case (s)
            stap_pkg::st_tlr:    n = m ? stap_pkg::st_tlr : stap_pkg::st_rti;
            stap_pkg::st_rti:    n = m ? stap_pkg::st_sel_dr
                                       : stap_pkg::st_rti;
            stap_pkg::st_sel_dr: n = m ? stap_pkg::st_sel_ir
                                       : stap_pkg::st_cap_dr;
            stap_pkg::st_cap_dr: n = m ? stap_pkg::st_ex1_dr
                                       : stap_pkg::st_sh_dr;
            stap_pkg::st_sh_dr:  n = m ? stap_pkg::st_ex1_dr
                                       : stap_pkg::st_sh_dr;
            stap_pkg::st_ex1_dr: n = m ? stap_pkg::st_upd_dr
                                       : stap_pkg::st_pau_dr;
            stap_pkg::st_pau_dr: n = m ? stap_pkg::st_ex2_dr
                                       : stap_pkg::st_pau_dr;
            stap_pkg::st_ex2_dr: n = m ? stap_pkg::st_upd_dr
                                       : stap_pkg::st_sh_dr;
            stap_pkg::st_upd_dr: n = m ? stap_pkg::st_sel_dr
                                       : stap_pkg::st_rti;
            stap_pkg::st_sel_ir: n = m ? stap_pkg::st_tlr
                                       : stap_pkg::st_cap_ir;
            stap_pkg::st_cap_ir: n = m ? stap_pkg::st_ex1_ir
                                       : stap_pkg::st_sh_ir;
            stap_pkg::st_sh_ir:  n = m ? stap_pkg::st_ex1_ir
                                       : stap_pkg::st_sh_ir;
            stap_pkg::st_ex1_ir: n = m ? stap_pkg::st_upd_ir
                                       : stap_pkg::st_pau_ir;
            stap_pkg::st_pau_ir: n = m ? stap_pkg::st_ex2_ir
                                       : stap_pkg::st_pau_ir;
            stap_pkg::st_ex2_ir: n = m ? stap_pkg::st_upd_ir
                                       : stap_pkg::st_sh_ir;
            stap_pkg::st_upd_ir: n = m ? stap_pkg::st_sel_dr
                                       : stap_pkg::st_rti;
        endcase
        return n;
    endfunction

    // Data register length follows the active instruction.
    always_comb begin
        if (st.ir == stap_pkg::IR_IDCODE) begin
            dr_len = stap_pkg::LEN_IDCODE;
        end else if (st.ir == stap_pkg::IR_EMUCTL) begin
            dr_len = stap_pkg::LEN_EMUCTL;
        end else begin
            dr_len = stap_pkg::LEN_BYPASS;
        end
    end

    // Edge actions of the port; unknown instructions fall back to bypass.
    always_comb begin
        next_st          = st;
        next_st.tck_prev = s_tck;
        next_st.scan     = s_trst;
        if (!s_trst) begin
            // Functional mode: scan pins have no effect at all.
            next_st.state    = stap_pkg::st_tlr;
            next_st.ir       = stap_pkg::IR_RESET;
            next_st.emu_dir  = stap_pkg::EMU_DIR_RST;
            next_st.tdo_oe_n = 1'b1;
        end else if (rise) begin
            next_st.state = next_tap(st.state, s_tms);
            if (st.state == stap_pkg::st_tlr) begin
                next_st.ir = stap_pkg::IR_RESET;
            end else if (st.state == stap_pkg::st_cap_ir) begin
                next_st.ir_sh = stap_pkg::IR_CAPTURE;
            end else if (st.state == stap_pkg::st_sh_ir) begin
                next_st.ir_sh = {s_tdi, st.ir_sh[3:1]};
            end else if (st.state == stap_pkg::st_upd_ir) begin
                next_st.ir = st.ir_sh;
            end else if (st.state == stap_pkg::st_cap_dr) begin
                if (st.ir == stap_pkg::IR_IDCODE) begin
                    next_st.dr = IDCODE_VALUE;
                end else if (st.ir == stap_pkg::IR_EMUCTL) begin
                    next_st.dr = {30'h0, st.emu_dir};
                end else begin
                    next_st.dr = 32'h0;
                end
            end else if (st.state == stap_pkg::st_sh_dr) begin
                next_st.dr = st.dr >> 1;
                next_st.dr[5'(dr_len - 6'h01)] = s_tdi;
            end else if (st.state == stap_pkg::st_upd_dr) begin
                if (st.ir == stap_pkg::IR_EMUCTL) begin
                    next_st.emu_dir = st.dr[1:0];
                end
            end
        end else if (fall) begin
            // Output moves half a TCK after the shift state is entered.
            if (st.state == stap_pkg::st_sh_ir) begin
                next_st.tdo      = st.ir_sh[0];
                next_st.tdo_oe_n = 1'b0;
            end else if (st.state == stap_pkg::st_sh_dr) begin
                next_st.tdo      = st.dr[0];
                next_st.tdo_oe_n = 1'b0;
            end else begin
                next_st.tdo_oe_n = 1'b1;
            end
        end
        // Emulation pins: direction bit 1 drives the core interrupt out.
        for (int i = 0; i < stap_pkg::EMU_W; i++) begin
            if (s_trst) begin
                next_st.emu_oe_n[i] = ~st.emu_dir[i];
                next_st.emu_out[i]  = core_irq[i];
                next_st.emu_irq[i]  = ~st.emu_dir[i] & s_emu[i];
            end else begin
                next_st.emu_oe_n[i] = 1'b1;
                next_st.emu_out[i]  = 1'b0;
                next_st.emu_irq[i]  = 1'b0;
            end
        end
    end

    // All state lives in one register; reset mirrors functional mode.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st          <= '0;
            st.state    <= stap_pkg::st_tlr;
            st.ir       <= stap_pkg::IR_RESET;
            st.emu_dir  <= stap_pkg::EMU_DIR_RST;
            st.tdo_oe_n <= 1'b1;
            st.emu_oe_n <= 2'h3;
        end else begin
            st <= next_st;
        end
    end

    assign tdo                      = st.tdo;
    assign tdo_oe_n                 = st.tdo_oe_n;
    assign emulator_irq_line_a_out  = st.emu_out[0];
    assign emulator_irq_line_a_oe_n = st.emu_oe_n[0];
    assign emulator_irq_line_b_out  = st.emu_out[1];
    assign emulator_irq_line_b_oe_n = st.emu_oe_n[1];
    assign emu_irq_a                = st.emu_irq[0];
    assign emu_irq_b                = st.emu_irq[1];
    assign scan_mode                = st.scan;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // Checks on the oversampled port behaviour.
    a_tms_idle_step: assert property (
        s_trst && rise && st.state == stap_pkg::st_rti && s_tms
        |=> st.state == stap_pkg::st_sel_dr)
        else $error("TMS high in idle did not select DR scan.");
    a_ir_shift_in: assert property (
        s_trst && rise && st.state == stap_pkg::st_sh_ir
        |=> st.ir_sh == {$past(s_tdi), $past(st.ir_sh[3:1])})
        else $error("TDI not shifted into instruction register.");
    a_tdo_dr_bit: assert property (
        s_trst && fall && st.state == stap_pkg::st_sh_dr
        |=> tdo == $past(st.dr[0]) && !tdo_oe_n)
        else $error("TDO does not show data register bit.");
    a_tdo_on_fall: assert property (
        $changed(tdo) |-> $past(fall))
        else $error("TDO changed away from a falling TCK edge.");
    a_tdo_float: assert property (
        s_trst && fall && st.state != stap_pkg::st_sh_dr
        && st.state != stap_pkg::st_sh_ir |=> tdo_oe_n)
        else $error("TDO driven outside a shift state.");
    // All released outputs come from the same register write.
    a_func_mode: assert property (
        !s_trst |=> tdo_oe_n && emulator_irq_line_a_oe_n
        && emulator_irq_line_b_oe_n && !emu_irq_a && !emu_irq_b)
        else $error("Scan pins active in functional mode.");
    a_tlr_hold: assert property (
        !s_trst [*2] |-> st.state == stap_pkg::st_tlr)
        else $error("TAP left reset while test reset low.");
    a_ir_update: assert property (
        s_trst && rise && st.state == stap_pkg::st_upd_ir
        |=> st.ir == $past(st.ir_sh))
        else $error("Instruction not updated from shift stage.");
    a_emu_drive: assert property (
        s_trst && st.emu_dir[0] |=> !emulator_irq_line_a_oe_n
        && emulator_irq_line_a_out == $past(core_irq_a))
        else $error("Emulation pin A not driven as configured.");
    a_scan_mode: assert property (
        s_trst |=> scan_mode)
        else $error("Scan mode not shown while test reset high.");

    c_shift_dr: cover property (fall && st.state == stap_pkg::st_sh_dr);
    c_upd_ir:   cover property (rise && st.state == stap_pkg::st_upd_ir);
    c_emu_out:  cover property (!emulator_irq_line_b_oe_n);
    c_irq_in:   cover property (emu_irq_a);
endmodule
`default_nettype wire

// ==== logic/stap_sync.sv ====
`default_nettype none
// Two-stage synchroniser for a vector of independent levels.
module stap_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } stap_sync_s;

    stap_sync_s st;
    stap_sync_s next_st;

    // The first stage feeds only the second stage.
    always_comb begin
        next_st.meta   = din;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.stable;
endmodule
`default_nettype wire

// ==== verif/stap_jtag_host.sv ====
`default_nettype none
// Scan controller model; test clock parked low between scans.
module stap_jtag_host (
    input  wire logic clock,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst,
    input  wire logic tdo,
    input  wire logic tdo_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    int bad;

    // Idle levels; scan control is taken from the start.
    initial begin
        tck  = 1'b0;
        tms  = 1'b1;
        tdi  = 1'b0;
        trst = 1'b1;
        bad  = 0;
    end

    // Drive test reset just after a system clock edge.
    task automatic set_trst(input logic v);
        @(posedge clock);
        #2;
        trst = v;
    endtask

    // One test clock period, four system clocks per phase, so 50% duty.
    // The output is taken at the rise, as a real controller does.
    task automatic cyc(input logic m, input logic d, input logic sh,
                       output logic q);
        tms = m;
        tdi = d;
        repeat (4) @(posedge clock);
        #2;
        tck = 1'b1;
        q   = tdo;
        // Without scan control the output must stay released.
        if (sh && tdo_oe_n !== ~trst) bad++;
        repeat (4) @(posedge clock);
        if (sh && tdo !== q) bad++;
        #2;
        tck = 1'b0;
    endtask

    // Five ones reach reset from any state, then idle.
    task automatic reset_tap();
        logic q;
        repeat (5) cyc(1'b1, 1'b0, 1'b0, q);
        cyc(1'b0, 1'b0, 1'b0, q);
    endtask

    // Full scan from idle back to idle, LSB first.
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = '0;
        cyc(1'b1, 1'b0, 1'b0, q);
        if (ir) cyc(1'b1, 1'b0, 1'b0, q);
        cyc(1'b0, 1'b0, 1'b0, q);
        cyc(1'b0, 1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            cyc(i == n - 1, din[i], 1'b1, q);
            dout[i] = q;
        end
        cyc(1'b1, 1'b0, 1'b0, q);
        cyc(1'b0, 1'b0, 1'b0, q);
        repeat (5) @(posedge clock);
        if (tdo_oe_n !== 1'b1) bad++;
    endtask
endmodule
`default_nettype wire

// ==== verif/test_scan_test_access_port.sv ====
`default_nettype none
// Bench: controller model on the test pins, emulator on the pins a and b.
module test_scan_test_access_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock, rst_n, tck, tms, tdi, trst, tdo, tdo_oe_n;
    logic        a_out, a_oe_n, b_out, b_oe_n, irq_a, irq_b, scan_mode;
    logic        core_a, core_b, emu_a, emu_b, pin_a, pin_b;
    logic [31:0] d;
    int          err_total;
    int          samples_checked;

    // Pin level: the device wins while it drives, else the emulator.
    assign pin_a = a_oe_n ? emu_a : a_out;
    assign pin_b = b_oe_n ? emu_b : b_out;

    stap_jtag_host host (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi),
        .trst(trst), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

    stap_core dut (.clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .trst(trst), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .emulator_irq_line_a_in(pin_a), .emulator_irq_line_a_out(a_out),
        .emulator_irq_line_a_oe_n(a_oe_n), .emulator_irq_line_b_in(pin_b),
        .emulator_irq_line_b_out(b_out), .emulator_irq_line_b_oe_n(b_oe_n),
        .core_irq_a(core_a), .core_irq_b(core_b), .emu_irq_a(irq_a),
        .emu_irq_b(irq_b), .scan_mode(scan_mode));

    // System clock, 25 ns.
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic close_out();
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Inputs of the core side and the emulator change just after an edge.
    task automatic drive(input logic ca, input logic cb, input logic ea,
                         input logic eb);
        @(posedge clock);
        #2;
        {core_a, core_b, emu_a, emu_b} = {ca, cb, ea, eb};
        repeat (6) @(posedge clock);
        #2;
    endtask

    task automatic t_idcode();
        host.reset_tap();
        host.scan(1'b0, 32, 32'h0, d);
        chk("idcode", stap_pkg::IDCODE_DEF, d);
    endtask

    // Direction both ways; capture shows the previous direction.
    task automatic t_emuctl();
        host.scan(1'b1, 4, {28'h0, stap_pkg::IR_EMUCTL}, d);
        chk("ir capture", {28'h0, stap_pkg::IR_CAPTURE}, d);
        host.scan(1'b0, 2, 32'h1, d);
        chk("dir capture", {30'h0, stap_pkg::EMU_DIR_RST}, d);
        drive(1'b1, 1'b0, 1'b0, 1'b1);
        chk1("a oe_n", 1'b0, a_oe_n);
        chk1("a out", 1'b1, a_out);
        chk1("b oe_n", 1'b1, b_oe_n);
        chk1("b irq", 1'b1, irq_b);
        host.scan(1'b0, 2, 32'h2, d);
        chk("dir capture 2", 32'h1, d);
        drive(1'b0, 1'b1, 1'b1, 1'b0);
        chk1("a oe_n 2", 1'b1, a_oe_n);
        chk1("a irq", 1'b1, irq_a);
        chk1("b oe_n 2", 1'b0, b_oe_n);
        chk1("b out", 1'b1, b_out);
    endtask

    // One-bit path: the first bit out is the captured zero.
    task automatic t_bypass();
        host.scan(1'b1, 4, {28'h0, stap_pkg::IR_BYPASS}, d);
        host.scan(1'b0, 8, 32'ha5, d);
        chk("bypass", 32'h4a, d);
    endtask

    // A scan while test reset is low must leave no trace.
    task automatic t_trst();
        logic q;
        host.set_trst(1'b0);
        repeat (5) @(posedge clock);
        #2;
        chk1("scan mode", 1'b0, scan_mode);
        chk1("tdo oe_n", 1'b1, tdo_oe_n);
        chk1("b oe_n off", 1'b1, b_oe_n);
        chk1("a irq off", 1'b0, irq_a);
        host.scan(1'b1, 4, {28'h0, stap_pkg::IR_BYPASS}, d);
        host.set_trst(1'b1);
        repeat (5) @(posedge clock);
        #2;
        chk1("scan mode on", 1'b1, scan_mode);
        chk1("b oe_n reset", 1'b1, b_oe_n);
        host.cyc(1'b0, 1'b0, 1'b0, q);
        host.scan(1'b0, 32, 32'h0, d);
        chk("idcode again", stap_pkg::IDCODE_DEF, d);
    endtask

    // Watchdog so that no hang outlives the run.
    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        close_out();
    end

    // Main sequence.
    initial begin
        err_total       = 0;
        samples_checked = 0;
        rst_n           = 1'b0;
        {core_a, core_b, emu_a, emu_b} = 4'h0;
        repeat (4) @(posedge clock);
        #2;
        chk1("reset oe_n", 1'b1, tdo_oe_n);
        rst_n = 1'b1;
        repeat (6) @(posedge clock);
        #2;
        t_idcode();
        t_emuctl();
        t_bypass();
        t_trst();
        chk("tdo timing", 32'h0, host.bad);
        close_out();
    end
endmodule
`default_nettype wire
